// ===== pmrc_top.sv
// Purpose: Digital control of three buck converters and two linear regulators.
// Assumes: Analog comparator flags and pins are asynchronous to clk_i.
// Notes:   APB register slave, zero wait states, one access cycle.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pmrc_top #(
    parameter int unsigned BIAS_CYCLES     = pmrc_pkg::BIAS_CYC,
    parameter int unsigned SOFT_CYCLES     = pmrc_pkg::SOFTSTART_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = pmrc_pkg::DEBOUNCE_CYC,
    parameter int unsigned RST_CYCLES      = pmrc_pkg::RST_DELAY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  buck_enable_pin_i,
    input  wire logic [2:0]  buck_default_select_i,
    input  wire logic        linear_regs_enable_i,
    input  wire logic        warm_reset_in_i,
    input  wire logic        supply_low_lockout_i,
    input  wire logic        thermal_shutdown_i,
    input  wire logic        always_on_rail_low_i,
    input  wire logic [2:0]  load_low_i,
    input  wire logic [2:0]  out_below_nom_i,
    input  wire logic [2:0]  out_below_2pct_i,
    input  wire logic [2:0]  out_precharged_i,
    input  wire logic [2:0]  dropout_i,
    input  wire logic [4:0]  rail_pg_low_i,
    output logic      [2:0]  buck_switch_en_o,
    output logic      [2:0]  buck_burst_o,
    output logic      [2:0]  buck_low_ripple_o,
    output logic      [2:0]  buck_high_side_on_o,
    output logic      [2:0]  buck_full_duty_o,
    output logic      [2:0]  buck_soft_start_o,
    output logic      [2:0]  buck_discharge_o,
    output logic      [2:0]  buck_default_high_o,
    output logic      [4:0]  core_vsel_o,
    output logic      [1:0]  ldo_on_o,
    output logic             rail_fault_irq_o,
    output logic             system_reset_out_n_o
);
    localparam int unsigned NS = 31;

    // Two-stage synchroniser for every asynchronous input
    logic [NS-1:0] async_in;
    logic [NS-1:0] sync1_q;
    logic [NS-1:0] sync2_q;
    assign async_in = {buck_enable_pin_i, buck_default_select_i, linear_regs_enable_i,
                       warm_reset_in_i, supply_low_lockout_i, thermal_shutdown_i,
                       always_on_rail_low_i, load_low_i, out_below_nom_i,
                       out_below_2pct_i, out_precharged_i, dropout_i, rail_pg_low_i};

    // No reset here, so default pins are already settled when reset releases
    always_ff @(posedge clk_i) begin
        sync1_q <= async_in;
        sync2_q <= sync1_q;
    end

    logic [2:0] en_pin_s;
    logic [2:0] def_sel_s;
    logic       ldo_pin_s;
    logic       warm_s;
    logic       supply_low_lockout_s;
    logic       hot_s;
    logic       rtc_low_s;
    logic [2:0] load_low_s;
    logic [2:0] below_nom_s;
    logic [2:0] below_2p_s;
    logic [2:0] prechg_s;
    logic [2:0] dropout_s;
    logic [4:0] pg_low_s;
    assign {en_pin_s, def_sel_s, ldo_pin_s, warm_s, supply_low_lockout_s, hot_s, rtc_low_s, load_low_s,
            below_nom_s, below_2p_s, prechg_s, dropout_s, pg_low_s} = sync2_q;

    // Software registers
    logic [3:0]  conv_ctrl_q;
    logic [2:0]  conv_ctrl2_q;
    logic [1:0]  linear_reg_control_reg_q;
    logic [4:0]  core_vsel_q;
    logic        warm_db_q;
    logic        warm_db_prev_q;
    logic        por_load_q;
    logic [31:0] prdata_q;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    logic [7:0]  addr;
    logic        warm_rise;

    assign addr      = paddr_i[7:0];
    assign mapped    = (paddr_i[31:8] == 24'h000000) && (addr == pmrc_pkg::OFF_CONV_CTRL
                       || addr == pmrc_pkg::OFF_CONV_CTRL2 || addr == pmrc_pkg::OFF_LINEAR_REG_CONTROL_REG
                       || addr == pmrc_pkg::OFF_STATUS || addr == pmrc_pkg::OFF_CORE_VSEL);
    assign setup     = psel_i && !penable_i;
    assign wr_en     = psel_i && penable_i && pwrite_i && mapped;
    assign pready_o  = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o  = prdata_q;
    assign warm_rise = warm_db_q && !warm_db_prev_q;

    function automatic logic [4:0] core_default(input logic high);
        return high ? pmrc_pkg::CORE_CODE_HI : pmrc_pkg::CORE_CODE_LO;
    endfunction

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conv_ctrl_q  <= pmrc_pkg::CONV_CTRL_RST;
            conv_ctrl2_q <= pmrc_pkg::CONV_CTRL2_RST;
            linear_reg_control_reg_q   <= pmrc_pkg::LINEAR_REG_CONTROL_REG_RST;
        end else if (wr_en) begin
            if (addr == pmrc_pkg::OFF_CONV_CTRL) begin
                conv_ctrl_q <= pwdata_i[3:0];
            end
            if (addr == pmrc_pkg::OFF_CONV_CTRL2) begin
                conv_ctrl2_q <= pwdata_i[2:0];
            end
            if (addr == pmrc_pkg::OFF_LINEAR_REG_CONTROL_REG) begin
                linear_reg_control_reg_q <= pwdata_i[1:0];
            end
        end
    end

    // Default-select pins caught once after reset release
    logic [2:0] def_high_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_load_q <= 1'b1;
            def_high_q <= 3'h0;
        end else begin
            por_load_q <= 1'b0;
            if (por_load_q) begin
                def_high_q <= def_sel_s;
            end
        end
    end
    assign buck_default_high_o = def_high_q;

    // Core voltage: software code, restored by warm reset or a cold load
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_vsel_q <= pmrc_pkg::CORE_CODE_LO;
        end else if (por_load_q || warm_rise) begin
            core_vsel_q <= core_default(def_sel_s[2]);
        end else if (wr_en && addr == pmrc_pkg::OFF_CORE_VSEL) begin
            core_vsel_q <= pwdata_i[4:0];
        end
    end
    assign core_vsel_o = core_vsel_q;

    // Warm reset debounce
    logic [pmrc_pkg::CNT_W-1:0] deb_cnt_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            deb_cnt_q      <= '0;
            warm_db_q      <= 1'b0;
            warm_db_prev_q <= 1'b0;
        end else begin
            warm_db_prev_q <= warm_db_q;
            if (warm_s == warm_db_q) begin
                deb_cnt_q <= '0;
            end else if (deb_cnt_q >= pmrc_pkg::CNT_W'(DEBOUNCE_CYCLES - 1)) begin
                deb_cnt_q <= '0;
                warm_db_q <= warm_s;
            end else begin
                deb_cnt_q <= deb_cnt_q + 1'b1;
            end
        end
    end

    // System reset output with capacitor-style delay
    logic [pmrc_pkg::CNT_W-1:0] rst_cnt_q;
    logic                       rst_n_q;
    logic                       rst_cause;
    assign rst_cause = rtc_low_s || warm_db_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_cnt_q <= '0;
            rst_n_q   <= 1'b0;
        end else if (rst_cause) begin
            rst_cnt_q <= '0;
            rst_n_q   <= 1'b0;
        end else if (!rst_n_q) begin
            if (rst_cnt_q >= pmrc_pkg::CNT_W'(RST_CYCLES - 1)) begin
                rst_n_q <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end
    assign system_reset_out_n_o = rst_n_q;

    // Per-converter start-up and mode control
    logic                        shutdown;
    logic [2:0]                  buck_on;
    pmrc_pkg::pmrc_state_e       st_q   [3];
    logic [pmrc_pkg::CNT_W-1:0]  cnt_q  [3];
    logic [2:0]                  bias_pre_q;
    assign shutdown = supply_low_lockout_s || hot_s;
    assign buck_on  = en_pin_s & {3{!shutdown}};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 3; i++) begin
                st_q[i]  <= pmrc_pkg::PMRC_OFF;
                cnt_q[i] <= '0;
            end
            bias_pre_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!buck_on[i]) begin
                    st_q[i]  <= pmrc_pkg::PMRC_OFF;
                    cnt_q[i] <= '0;
                end else begin
                    unique case (st_q[i])
                        pmrc_pkg::PMRC_OFF: begin
                            st_q[i]       <= pmrc_pkg::PMRC_BIAS;
                            cnt_q[i]      <= '0;
                            bias_pre_q[i] <= 1'b0;
                        end
                        pmrc_pkg::PMRC_BIAS: begin
                            if (prechg_s[i]) begin
                                bias_pre_q[i] <= 1'b1;
                            end
                            if (cnt_q[i] >= pmrc_pkg::CNT_W'(BIAS_CYCLES - 1)) begin
                                st_q[i]  <= pmrc_pkg::PMRC_SOFT;
                                cnt_q[i] <= '0;
                            end else begin
                                cnt_q[i] <= cnt_q[i] + 1'b1;
                            end
                        end
                        pmrc_pkg::PMRC_SOFT: begin
                            // Pre-charged output ends the ramp once it is caught up
                            if (cnt_q[i] >= pmrc_pkg::CNT_W'(SOFT_CYCLES - 1)
                                || (bias_pre_q[i] && !below_nom_s[i])) begin
                                st_q[i]  <= pmrc_pkg::PMRC_FIXED;
                                cnt_q[i] <= '0;
                            end else begin
                                cnt_q[i] <= cnt_q[i] + 1'b1;
                            end
                        end
                        pmrc_pkg::PMRC_FIXED: begin
                            cnt_q[i] <= '0;
                            if (load_low_s[i] && !conv_ctrl_q[pmrc_pkg::CC_BURST_DIS_LSB + i]
                                && !dropout_s[i]) begin
                                st_q[i] <= pmrc_pkg::PMRC_BURST;
                            end
                        end
                        pmrc_pkg::PMRC_BURST: begin
                            if (conv_ctrl_q[pmrc_pkg::CC_BURST_DIS_LSB + i]) begin
                                st_q[i] <= pmrc_pkg::PMRC_FIXED;
                            end else if (below_2p_s[i]) begin
                                st_q[i] <= pmrc_pkg::PMRC_FIXED;
                            end else if (below_nom_s[i] && cnt_q[i]
                                         >= pmrc_pkg::CNT_W'(pmrc_pkg::BURST_MAX_CYC)) begin
                                st_q[i] <= pmrc_pkg::PMRC_FIXED;
                            end
                            // Burst length counts only while the high side delivers
                            if (below_nom_s[i]) begin
                                cnt_q[i] <= cnt_q[i] + 1'b1;
                            end else begin
                                cnt_q[i] <= '0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Converter outputs, all from flip-flops
    logic [2:0] sw_en_q;
    logic [2:0] burst_q;
    logic [2:0] ripple_q;
    logic [2:0] hs_q;
    logic [2:0] full_q;
    logic [2:0] soft_q;
    logic [2:0] dis_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_en_q  <= 3'h0;
            burst_q  <= 3'h0;
            ripple_q <= 3'h0;
            hs_q     <= 3'h0;
            full_q   <= 3'h0;
            soft_q   <= 3'h0;
            dis_q    <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                sw_en_q[i] <= st_q[i] == pmrc_pkg::PMRC_SOFT
                              || st_q[i] == pmrc_pkg::PMRC_FIXED
                              || st_q[i] == pmrc_pkg::PMRC_BURST;
                soft_q[i]  <= st_q[i] == pmrc_pkg::PMRC_SOFT;
                burst_q[i] <= st_q[i] == pmrc_pkg::PMRC_BURST;
                ripple_q[i] <= st_q[i] == pmrc_pkg::PMRC_BURST
                               && conv_ctrl_q[pmrc_pkg::CC_LOW_RIPPLE];
                hs_q[i]    <= (st_q[i] == pmrc_pkg::PMRC_BURST && below_nom_s[i])
                              || (st_q[i] == pmrc_pkg::PMRC_FIXED && dropout_s[i]);
                full_q[i]  <= st_q[i] == pmrc_pkg::PMRC_FIXED && dropout_s[i];
                // Never pulls down while starting, so a pre-charged output survives
                dis_q[i]   <= !buck_on[i] && st_q[i] == pmrc_pkg::PMRC_OFF
                              && conv_ctrl2_q[i];
            end
        end
    end
    assign buck_switch_en_o    = sw_en_q;
    assign buck_burst_o        = burst_q;
    assign buck_low_ripple_o   = ripple_q;
    assign buck_high_side_on_o = hs_q;
    assign buck_full_duty_o    = full_q;
    assign buck_soft_start_o   = soft_q;
    assign buck_discharge_o    = dis_q;

    // Linear regulators and rail status
    logic [1:0] ldo_q;
    logic [4:0] fault_q;
    logic       irq_q;
    logic [4:0] rail_en;
    assign rail_en = {sw_en_q, ldo_q};
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ldo_q   <= 2'h0;
            fault_q <= 5'h00;
            irq_q   <= 1'b0;
        end else begin
            ldo_q   <= {2{ldo_pin_s && !shutdown}} & linear_reg_control_reg_q;
            fault_q <= pg_low_s & rail_en;
            irq_q   <= |(pg_low_s & rail_en);
        end
    end
    assign ldo_on_o         = ldo_q;
    assign rail_fault_irq_o = irq_q;

    // Read data captured in the setup phase
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= 32'h00000000;
            unique case (addr)
                pmrc_pkg::OFF_CONV_CTRL:  prdata_q[3:0] <= conv_ctrl_q;
                pmrc_pkg::OFF_CONV_CTRL2: prdata_q[2:0] <= conv_ctrl2_q;
                pmrc_pkg::OFF_LINEAR_REG_CONTROL_REG:   prdata_q[1:0] <= linear_reg_control_reg_q;
                pmrc_pkg::OFF_STATUS: begin
                    prdata_q[pmrc_pkg::ST_FAULT_LSB +: 5] <= fault_q;
                    prdata_q[pmrc_pkg::ST_BURST_LSB +: 3] <= burst_q;
                    prdata_q[pmrc_pkg::ST_RUN_LSB +: 5]   <= rail_en;
                    prdata_q[pmrc_pkg::ST_RESET_BIT]      <= !rst_n_q;
                end
                pmrc_pkg::OFF_CORE_VSEL:  prdata_q[4:0] <= core_vsel_q;
                default:                  prdata_q <= 32'h00000000;
            endcase
        end
    end
endmodule // pmrc_top

// ===== pmrc_pkg.sv
// Purpose: Constants shared by the regulator control logic.
// Assumes: 100 MHz logic clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package pmrc_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_NS  = 1000 / CLK_MHZ;

    // Register byte offsets
    localparam logic [7:0] OFF_CONV_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CONV_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_LINEAR_REG_CONTROL_REG   = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h0C;
    localparam logic [7:0] OFF_CORE_VSEL  = 8'h10;

    // Field positions
    localparam int unsigned CC_BURST_DIS_LSB = 0;
    localparam int unsigned CC_LOW_RIPPLE    = 3;
    localparam int unsigned ST_FAULT_LSB     = 0;
    localparam int unsigned ST_BURST_LSB     = 8;
    localparam int unsigned ST_RUN_LSB       = 16;
    localparam int unsigned ST_RESET_BIT     = 24;

    // Reset values
    localparam logic [3:0] CONV_CTRL_RST  = 4'h0;
    localparam logic [2:0] CONV_CTRL2_RST = 3'h0;
    localparam logic [1:0] LINEAR_REG_CONTROL_REG_RST   = 2'h3;

    // Core converter voltage codes for the two pin defaults (1.3 V / 1.55 V)
    localparam logic [4:0] CORE_CODE_LO = 5'h0A;
    localparam logic [4:0] CORE_CODE_HI = 5'h0F;

    // Timing
    localparam int unsigned BIAS_US      = 170;
    localparam int unsigned SOFTSTART_US = 750;
    localparam int unsigned BURST_MAX_NS = 10670;
    localparam int unsigned DEBOUNCE_MS  = 30;
    localparam int unsigned RST_DELAY_MS = 100;

    localparam int unsigned BIAS_CYC      = BIAS_US * 1000 / CLK_NS;
    localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * 1000 / CLK_NS;
    localparam int unsigned BURST_MAX_CYC = BURST_MAX_NS / CLK_NS;
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * 1000000 / CLK_NS;
    localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * 1000000 / CLK_NS;

    localparam int unsigned CNT_W = 24;

    typedef enum logic [2:0] {
        PMRC_OFF,
        PMRC_BIAS,
        PMRC_SOFT,
        PMRC_FIXED,
        PMRC_BURST
    } pmrc_state_e;
endpackage : pmrc_pkg

// ===== pmrc_chk.sv
// Purpose: Port-level checks on the regulator control block.
// Assumes: Inputs pass two sync flops, outputs land three edges later (converter outputs four).
// Notes:   Bound into pmrc_top below.
`timescale 1ns/1ps
module pmrc_chk #(
    parameter int unsigned BIAS_CYCLES = 20
) (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pready_o,
    input wire logic [2:0] buck_enable_pin_i,
    input wire logic       supply_low_lockout_i,
    input wire logic       always_on_rail_low_i,
    input wire logic [4:0] rail_pg_low_i,
    input wire logic [2:0] buck_switch_en_o,
    input wire logic [2:0] buck_burst_o,
    input wire logic [2:0] buck_low_ripple_o,
    input wire logic [2:0] buck_high_side_on_o,
    input wire logic [2:0] buck_full_duty_o,
    input wire logic [2:0] buck_discharge_o,
    input wire logic [1:0] ldo_on_o,
    input wire logic       rail_fault_irq_o,
    input wire logic       system_reset_out_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready low in access phase");
    a_bias_wait: assert property ($rose(buck_switch_en_o[0]) |->
        $past(buck_enable_pin_i[0], BIAS_CYCLES)) else $error("switching before bias delay");
    a_lockout_all_off: assert property (supply_low_lockout_i [*5] |->
        buck_switch_en_o == 3'h0 && ldo_on_o == 2'h0) else $error("rail on in lockout");
    a_pin_low_off: assert property ((!buck_enable_pin_i[0]) [*5] |->
        !buck_switch_en_o[0]) else $error("buck switching with pin low");
    a_irq_quiet: assert property ((rail_pg_low_i == 5'h00) [*5] |->
        !rail_fault_irq_o) else $error("interrupt without low rail");
    a_reset_low_rail: assert property (always_on_rail_low_i [*5] |->
        !system_reset_out_n_o) else $error("reset released on low rail");
    a_ripple_burst: assert property (buck_low_ripple_o[0] |-> buck_burst_o[0])
        else $error("low ripple outside burst");
    a_discharge_off: assert property (buck_discharge_o[0] |-> !buck_switch_en_o[0])
        else $error("discharge while switching");
    a_full_duty_hs: assert property (buck_full_duty_o[0] |->
        buck_high_side_on_o[0] && !buck_burst_o[0]) else $error("full duty without high side");
    a_hs_cause: assert property (buck_high_side_on_o[0] |->
        buck_burst_o[0] || buck_full_duty_o[0]) else $error("high side on without cause");
endmodule // pmrc_chk
bind pmrc_top pmrc_chk #(.BIAS_CYCLES(BIAS_CYCLES)) pmrc_chk_inst (.clk_i, .rstn_i, .psel_i,
    .penable_i, .pready_o, .buck_enable_pin_i, .supply_low_lockout_i, .always_on_rail_low_i,
    .rail_pg_low_i, .buck_switch_en_o, .buck_burst_o, .buck_low_ripple_o, .buck_high_side_on_o,
    .buck_full_duty_o, .buck_discharge_o, .ldo_on_o, .rail_fault_irq_o, .system_reset_out_n_o);

// ===== pmrc_host.sv
// Purpose: Host processor model driving enables and warm reset.
// Assumes: Requests come from the bench, pins change after an edge.
// Notes:   Reports whether the host is held in reset.
`timescale 1ns/1ps
module pmrc_host (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [2:0] en_req_i,
    input  wire logic       ldo_req_i,
    input  wire logic       warm_req_i,
    input  wire logic       system_reset_out_n_i,
    output logic      [2:0] buck_enable_pin_o,
    output logic            linear_regs_enable_o,
    output logic            warm_reset_in_o,
    output logic            held_o
);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buck_enable_pin_o    <= 3'h0;
            linear_regs_enable_o <= 1'b0;
            warm_reset_in_o      <= 1'b0;
            held_o               <= 1'b1;
        end else begin
            buck_enable_pin_o    <= en_req_i;
            linear_regs_enable_o <= ldo_req_i;
            warm_reset_in_o      <= warm_req_i;
            held_o               <= !system_reset_out_n_i;
        end
    end
endmodule // pmrc_host

// ===== tb.sv
// Purpose: Self-checking bench for the regulator control block.
// Assumes: Shortened bias, soft-start, debounce and reset counts.
// Notes:   Registers are reached over APB with zero wait states.
`timescale 1ns/1ps
module tb;
    localparam int unsigned BIAS = 20;
    localparam int unsigned SOFT = 50;
    localparam int unsigned DEB  = 10;
    localparam int unsigned RSTC = 30;
    logic        clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, rd;
    logic        pready_o, pslverr_o, err, ldo_req = 1'b0, warm_req = 1'b0, held;
    logic        linear_regs_enable_i, warm_reset_in_i, rail_fault_irq_o, system_reset_out_n_o;
    logic        supply_low_lockout_i = 1'b0, thermal_shutdown_i = 1'b0, always_on_rail_low_i = 1'b0;
    logic [2:0]  en_req = '0, buck_enable_pin_i, buck_default_select_i = 3'h5, load_low_i = '0;
    logic [2:0]  out_below_nom_i = '0, out_below_2pct_i = '0, out_precharged_i = '0, dropout_i = '0;
    logic [4:0]  rail_pg_low_i = '0, core_vsel_o;
    logic [2:0]  buck_switch_en_o, buck_burst_o, buck_low_ripple_o, buck_high_side_on_o;
    logic [2:0]  buck_full_duty_o, buck_soft_start_o, buck_discharge_o, buck_default_high_o;
    logic [1:0]  ldo_on_o;
    int          error_cnt = 0, n_checks = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    pmrc_top #(.BIAS_CYCLES(BIAS), .SOFT_CYCLES(SOFT), .DEBOUNCE_CYCLES(DEB), .RST_CYCLES(RSTC))
    pmrc_top_inst (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .buck_enable_pin_i, .buck_default_select_i,
        .linear_regs_enable_i, .warm_reset_in_i, .supply_low_lockout_i, .thermal_shutdown_i,
        .always_on_rail_low_i, .load_low_i, .out_below_nom_i, .out_below_2pct_i,
        .out_precharged_i, .dropout_i, .rail_pg_low_i, .buck_switch_en_o, .buck_burst_o,
        .buck_low_ripple_o, .buck_high_side_on_o, .buck_full_duty_o, .buck_soft_start_o,
        .buck_discharge_o, .buck_default_high_o, .core_vsel_o, .ldo_on_o, .rail_fault_irq_o,
        .system_reset_out_n_o);
    pmrc_host pmrc_host_inst (.clk_i, .rstn_i, .en_req_i(en_req), .ldo_req_i(ldo_req),
        .warm_req_i(warm_req), .system_reset_out_n_i(system_reset_out_n_o),
        .buck_enable_pin_o(buck_enable_pin_i), .linear_regs_enable_o(linear_regs_enable_i),
        .warm_reset_in_o(warm_reset_in_i), .held_o(held));
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= {24'h0, a};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd & 32'h1F);
    endtask
    initial begin
        wt(6);
        rstn_i <= 1'b1;
        wt(2);
        chk("sysrst", 32'h0, system_reset_out_n_o);
        chk("defsel", 32'h5, buck_default_high_o);
        rchk("conv", pmrc_pkg::OFF_CONV_CTRL, 32'h0);
        rchk("conv2", pmrc_pkg::OFF_CONV_CTRL2, 32'h0);
        rchk("ldo", pmrc_pkg::OFF_LINEAR_REG_CONTROL_REG, 32'h3);
        rchk("core", pmrc_pkg::OFF_CORE_VSEL, 32'h0F);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, err);
        wt(RSTC);
        chk("sysrst", 32'h1, system_reset_out_n_o);
        en_req <= 3'h1;
        wt(BIAS);
        chk("bias", 32'h0, buck_switch_en_o);
        wt(8);
        chk("soft", 32'h1, buck_soft_start_o);
        wt(SOFT);
        chk("fixed", 32'h01, {buck_soft_start_o, buck_switch_en_o});
        load_low_i <= 3'h1;
        wt(6);
        chk("burst", 32'h1, buck_burst_o);
        out_below_nom_i <= 3'h1;
        wt(6);
        chk("hs", 32'h1, buck_high_side_on_o);
        out_below_nom_i <= 3'h0;
        wt(6);
        chk("hs", 32'h0, buck_high_side_on_o);
        apb(1'b1, pmrc_pkg::OFF_CONV_CTRL, 32'h8);
        wt(4);
        chk("ripple", 32'h1, buck_low_ripple_o);
        load_low_i <= 3'h0;
        out_below_2pct_i <= 3'h1;
        wt(6);
        chk("exit", 32'h0, buck_burst_o);
        out_below_2pct_i <= 3'h0;
        load_low_i <= 3'h1;
        wt(6);
        load_low_i <= 3'h0;
        out_below_nom_i <= 3'h1;
        wt(1000);
        chk("long", 32'h1, buck_burst_o);
        wt(80);
        chk("long", 32'h0, buck_burst_o);
        out_below_nom_i <= 3'h0;
        load_low_i <= 3'h1;
        apb(1'b1, pmrc_pkg::OFF_CONV_CTRL, 32'h9);
        wt(8);
        chk("nobst", 32'h0, {buck_burst_o, buck_low_ripple_o});
        dropout_i <= 3'h1;
        wt(6);
        chk("duty", 32'h09, {buck_full_duty_o, buck_high_side_on_o});
        dropout_i <= 3'h0;
        rail_pg_low_i <= 5'h0C;
        wt(6);
        chk("irq", 32'h1, rail_fault_irq_o);
        rchk("stat", pmrc_pkg::OFF_STATUS, 32'h04);
        apb(1'b1, pmrc_pkg::OFF_CONV_CTRL2, 32'h1);
        en_req <= 3'h0;
        wt(7);
        chk("dis", 32'h08, {buck_discharge_o, buck_switch_en_o});
        chk("irq", 32'h0, rail_fault_irq_o);
        rchk("stat", pmrc_pkg::OFF_STATUS, 32'h0);
        rail_pg_low_i <= 5'h00;
        ldo_req <= 1'b1;
        wt(6);
        chk("ldo", 32'h3, ldo_on_o);
        apb(1'b1, pmrc_pkg::OFF_LINEAR_REG_CONTROL_REG, 32'h1);
        en_req <= 3'h1;
        for (int i = 0; i < 2; i++) begin
            wt(BIAS + 8);
            chk("on", 32'h05, {buck_switch_en_o, ldo_on_o});
            {thermal_shutdown_i, supply_low_lockout_i} <= 2'(1 << i);
            wt(6);
            chk("down", 32'h0, {buck_switch_en_o, ldo_on_o});
            {thermal_shutdown_i, supply_low_lockout_i} <= 2'h0;
        end
        apb(1'b1, pmrc_pkg::OFF_CORE_VSEL, 32'h5);
        warm_req <= 1'b1;
        wt(4);
        warm_req <= 1'b0;
        wt(DEB + 8);
        chk("glitch", 32'h1, system_reset_out_n_o);
        rchk("core", pmrc_pkg::OFF_CORE_VSEL, 32'h05);
        warm_req <= 1'b1;
        wt(DEB + 8);
        chk("warm", 32'h0, system_reset_out_n_o);
        chk("vsel", 32'h0F, core_vsel_o);
        chk("held", 32'h1, held);
        warm_req <= 1'b0;
        rchk("core", pmrc_pkg::OFF_CORE_VSEL, 32'h0F);
        rchk("conv2", pmrc_pkg::OFF_CONV_CTRL2, 32'h1);
        wt(DEB + RSTC + 10);
        chk("sysrst", 32'h1, system_reset_out_n_o);
        always_on_rail_low_i <= 1'b1;
        wt(6);
        chk("rail", 32'h0, system_reset_out_n_o);
        always_on_rail_low_i <= 1'b0;
        stop_test();
    end
endmodule // tb
